/* hw/float_compare_ge_gt_unit.sv */
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// What this block does
// [RQ1] Greater-or-equal compare returns one or zero
// [RQ2] Greater-than compare returns one only when strictly greater
// [RQ3] Operands are single floats, result is integer
// [RQ4] Flags-only op returns vector, status untouched
// [RQ5] Vector bits six to zero, upper bits zero
// [RQ6] Denormal becomes zero and sets input-flushed flag
// [RQ7] Flags-only denormal sets returned bit five
// [RQ8] Compare exceptions set sticky status flags
// [RQ9] Status update lands with destination write
// [RQ10] Simultaneous updates OR into existing flags
// [RQ11] False guard blocks destination and status update
// [RQ12] False guard blocks flags-only destination write
// [RQ13] One cycle latency, single issue slot set by ISSUE_SLOT (1 to 5), third by default
// [RQ14] NaN yields zero and raises bad operation
module float_compare_ge_gt_unit #(
    parameter int ISSUE_SLOT = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input fcmp_pkg::cmp_issue_t issue,
    input wire logic [fcmp_pkg::FLAG_W-1:0] other_flags,
    output fcmp_pkg::cmp_result_t result,
    output logic [fcmp_pkg::FLAG_W-1:0] program_status_word,
    input fcmp_pkg::wb_req_t wb_req,
    output fcmp_pkg::wb_rsp_t wb_rsp,
    output logic irq
);
    import fcmp_pkg::*;

    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    generate
        if (ISSUE_SLOT < 1 || ISSUE_SLOT > SLOT_COUNT) begin : g_bad_slot
            $error("ISSUE_SLOT must lie between 1 and 5.");
        end
    endgenerate

    localparam logic [SLOT_W-1:0] SLOT_SEL = SLOT_W'(ISSUE_SLOT);

    typedef struct packed {
        cmp_result_t result;
        logic [FLAG_W-1:0] psw;
        logic [EVT_W-1:0] evt_status;
        logic [EVT_W-1:0] evt_mask;
        logic [FLAG_W-1:0] last_flags;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    state_t state_q;
    state_t state_d;

    // ****************************************************************
    // Operand classification.
    // ****************************************************************
    logic [1:0] is_nan;
    logic [1:0] is_denorm;
    logic [1:0][31:0] key;
    logic [1:0][31:0] operand;

    assign operand[0] = issue.first_source;
    assign operand[1] = issue.second_source;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_operand
            logic [7:0] exp_f;
            logic mant_nz;
            logic zero_mag;
            assign exp_f = operand[i][EXP_HI:EXP_LO];
            assign mant_nz = |operand[i][MANT_HI:0];
            assign is_nan[i] = (exp_f == EXP_MAX) && mant_nz; // [RQ3]
            assign is_denorm[i] = (exp_f == EXP_MIN) && mant_nz; // [RQ6]
            assign zero_mag = (exp_f == EXP_MIN); // [RQ6]
            always_comb begin
                if (zero_mag) begin
                    key[i] = {1'b1, WORD_ZERO[30:0]};
                end else if (operand[i][SIGN_BIT]) begin
                    key[i] = ~operand[i];
                end else begin
                    key[i] = {1'b1, operand[i][30:0]};
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Compare and exception vector.
    // ****************************************************************
    logic any_nan;
    logic ge_true;
    logic gt_true;
    logic cmp_true;
    logic [FLAG_W-1:0] cmp_flags;
    logic accepted;
    logic known_op;
    logic flags_only;

    assign any_nan = |is_nan;
    assign ge_true = !any_nan && (key[0] >= key[1]); // [RQ1] [RQ14]
    assign gt_true = !any_nan && (key[0] > key[1]); // [RQ2] [RQ14]
    assign cmp_true = (issue.opcode == OP_GTR) ? gt_true : ge_true;
    assign known_op = (issue.opcode == OP_GTR) || (issue.opcode == OP_GEQ) || (issue.opcode == OP_GEQ_FLAGS);
    assign flags_only = (issue.opcode == OP_GEQ_FLAGS);
    assign accepted = issue.valid && known_op && (issue.slot == SLOT_SEL); // [RQ13]

    always_comb begin
        cmp_flags = '0;
        cmp_flags[INPUT_FLUSHED_BIT] = |is_denorm; // [RQ6] [RQ7]
        cmp_flags[BAD_OPERATION_BIT] = any_nan; // [RQ14]
    end

    // ****************************************************************
    // Next state.
    // ****************************************************************
    logic bus_hit;
    logic bus_write;
    logic do_write;
    logic [FLAG_W-1:0] psw_base;
    logic [FLAG_W-1:0] psw_update;
    logic [EVT_W-1:0] evt_set;

    assign bus_hit = wb_req.cyc && wb_req.stb && !state_q.ack;
    assign bus_write = bus_hit && wb_req.we && wb_req.sel[0];
    assign do_write = accepted && issue.guard[0]; // [RQ11] [RQ12]

    always_comb begin
        state_d = state_q;
        psw_update = other_flags; // [RQ10]
        evt_set = '0;

        state_d.result.write = 1'b0;
        if (do_write) begin
            state_d.result.write = 1'b1; // [RQ13]
            state_d.result.dest = issue.dest;
            state_d.last_flags = cmp_flags;
            evt_set[EVT_RESULT] = 1'b1;
            if (flags_only) begin
                state_d.result.data = {25'h0000000, cmp_flags}; // [RQ4] [RQ5] [RQ7]
            end else begin
                state_d.result.data = cmp_true ? WORD_ONE : WORD_ZERO; // [RQ1] [RQ2] [RQ3]
                psw_update = psw_update | cmp_flags; // [RQ8] [RQ9]
                evt_set[EVT_EXCEPTION] = |cmp_flags;
            end
        end
        if (issue.valid && issue.slot != SLOT_SEL) begin
            evt_set[EVT_BAD_SLOT] = 1'b1; // [RQ13]
        end

        psw_base = state_q.psw;
        if (bus_write && wb_req.adr == ADR_PSW) begin
            psw_base = wb_req.dat[FLAG_W-1:0];
        end
        state_d.psw = psw_base | psw_update; // [RQ8] [RQ10]

        if (bus_write && wb_req.adr == ADR_IRQ_STATUS) begin
            state_d.evt_status = state_q.evt_status & ~wb_req.dat[EVT_W-1:0];
        end
        state_d.evt_status = state_d.evt_status | evt_set;
        if (bus_write && wb_req.adr == ADR_IRQ_MASK) begin
            state_d.evt_mask = wb_req.dat[EVT_W-1:0];
        end
        state_d.irq = |(state_d.evt_status & state_d.evt_mask);

        state_d.ack = bus_hit;
        state_d.rdata = WORD_ZERO;
        if (bus_hit && !wb_req.we) begin
            case (wb_req.adr)
                ADR_PSW: state_d.rdata = {25'h0000000, state_q.psw};
                ADR_IRQ_STATUS: state_d.rdata = {29'h00000000, state_q.evt_status};
                ADR_IRQ_MASK: state_d.rdata = {29'h00000000, state_q.evt_mask};
                ADR_UNIT_STATUS: state_d.rdata = {25'h0000000, state_q.last_flags};
                default: state_d.rdata = WORD_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result = state_q.result;
    assign program_status_word = state_q.psw;
    assign wb_rsp.ack = state_q.ack;
    assign wb_rsp.dat = state_q.rdata;
    assign irq = state_q.irq;

endmodule

/* include/fcmp_pkg.sv */
package fcmp_pkg;

    // ****************************************************************
    // Operation codes and issue slots.
    // ****************************************************************
    localparam logic [7:0] OP_GTR = 8'h90;
    localparam logic [7:0] OP_GEQ = 8'h92;
    localparam logic [7:0] OP_GEQ_FLAGS = 8'h93;
    localparam int SLOT_W = 3;
    localparam int SLOT_COUNT = 5;
    localparam int DEST_W = 7;

    // ****************************************************************
    // Exception vector layout.
    // ****************************************************************
    localparam int FLAG_W = 7;
    localparam int DIVIDE_BY_ZERO_BIT = 0;
    localparam int INEXACT_BIT = 1;
    localparam int UNDERFLOW_BIT = 2;
    localparam int OVERFLOW_BIT = 3;
    localparam int BAD_OPERATION_BIT = 4;
    localparam int INPUT_FLUSHED_BIT = 5;
    localparam int OUTPUT_FLUSHED_BIT = 6;

    // ****************************************************************
    // Single precision fields.
    // ****************************************************************
    localparam int SIGN_BIT = 31;
    localparam int EXP_HI = 30;
    localparam int EXP_LO = 23;
    localparam int MANT_HI = 22;
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic [7:0] EXP_MIN = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE = 32'h0000_0001;

    // ****************************************************************
    // Register map, byte addresses.
    // ****************************************************************
    localparam int ADR_W = 4;
    localparam logic [3:0] ADR_PSW = 4'h0;
    localparam logic [3:0] ADR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADR_UNIT_STATUS = 4'hC;
    localparam int EVT_W = 3;
    localparam int EVT_RESULT = 0;
    localparam int EVT_EXCEPTION = 1;
    localparam int EVT_BAD_SLOT = 2;
    localparam logic [FLAG_W-1:0] PSW_RESET = 7'h00;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

    typedef struct packed {
        logic valid;
        logic [SLOT_W-1:0] slot;
        logic [7:0] opcode;
        logic [31:0] guard;
        logic [31:0] first_source;
        logic [31:0] second_source;
        logic [DEST_W-1:0] dest;
    } cmp_issue_t;

    typedef struct packed {
        logic write;
        logic [DEST_W-1:0] dest;
        logic [31:0] data;
    } cmp_result_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

endpackage

/* testbench/fcmp_monitor.sv */
`timescale 1ns/1ps
module fcmp_monitor #(
    parameter int ISSUE_SLOT = 3
) (
    input wire logic clk,
    input wire logic sys_rst,
    input fcmp_pkg::cmp_issue_t issue,
    input wire logic [fcmp_pkg::FLAG_W-1:0] other_flags,
    input fcmp_pkg::cmp_result_t result,
    input wire logic [fcmp_pkg::FLAG_W-1:0] program_status_word,
    input fcmp_pkg::wb_req_t wb_req,
    input fcmp_pkg::wb_rsp_t wb_rsp,
    input wire logic irq
);
    import fcmp_pkg::*;
    // **********
    // Port checks.
    // **********
    logic take, flg, nan2, den2, wr_busy;
    assign flg = issue.opcode == OP_GEQ_FLAGS;
    assign take = issue.valid && issue.slot == ISSUE_SLOT && issue.guard[0] &&
        (issue.opcode == OP_GEQ || issue.opcode == OP_GTR || flg);
    assign nan2 = issue.second_source[EXP_HI:EXP_LO] == EXP_MAX && issue.second_source[MANT_HI:0] != '0;
    assign den2 = issue.second_source[EXP_HI:EXP_LO] == EXP_MIN && issue.second_source[MANT_HI:0] != '0;
    assign wr_busy = (wb_req.cyc && wb_req.stb && wb_req.we) || wb_rsp.ack;
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_write_lat: assert property (take |=> result.write)
        else $error("late result");
    chk_slot_refuse: assert property (issue.valid && issue.slot != ISSUE_SLOT |=> !result.write)
        else $error("wrong slot wrote");
    chk_psw_kept: assert property (issue.valid && (!issue.guard[0] || flg) && other_flags == '0 && !wr_busy
        |=> $stable(program_status_word))
        else $error("status word moved");
    chk_psw_sticky: assert property (!wr_busy |=> (program_status_word & $past(program_status_word))
        == $past(program_status_word))
        else $error("flag dropped");
    chk_or_merge: assert property (other_flags != '0 |=> (program_status_word & $past(other_flags))
        == $past(other_flags))
        else $error("merge lost");
    chk_nan_zero: assert property (take && !flg && nan2 |=> result.data == WORD_ZERO
        && program_status_word[BAD_OPERATION_BIT])
        else $error("nan result");
    chk_denorm_flag: assert property (take && !flg && den2 |=> result.write
        && program_status_word[INPUT_FLUSHED_BIT])
        else $error("flush flag");
    chk_flags_denorm: assert property (take && flg && den2 |=> result.data[INPUT_FLUSHED_BIT])
        else $error("vector flush bit");
    chk_upper_zero: assert property (result.write |-> result.data[31:FLAG_W] == '0)
        else $error("upper bits set");
    cover property (take && flg);
    cover property (issue.valid && !issue.guard[0]);
    cover property (irq);
endmodule
bind float_compare_ge_gt_unit fcmp_monitor #(.ISSUE_SLOT(ISSUE_SLOT)) i_fcmp_monitor (.clk(clk), .sys_rst(sys_rst),
    .issue(issue), .other_flags(other_flags), .result(result), .program_status_word(program_status_word),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .irq(irq));

/* testbench/dest_regfile.sv */
`timescale 1ns/1ps
module dest_regfile (
    input wire logic clk,
    input fcmp_pkg::cmp_result_t result
);
    import fcmp_pkg::*;
    // **********
    // Destination registers, preset so a stray write shows.
    // **********
    logic [31:0] regs_q [128];
    initial begin
        foreach (regs_q[k]) regs_q[k] = 32'hA5A5_A5A5;
    end
    always @(posedge clk) begin
        if (result.write) begin
            regs_q[result.dest] <= result.data;
        end
    end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("unexpected %s %h %h", n, e, g); end end
module testbench;
    import fcmp_pkg::*;
    // **********
    // Bench.
    // **********
    logic clk = 0, sys_rst = 1, irq;
    cmp_issue_t issue = '0;
    cmp_result_t result;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    logic [FLAG_W-1:0] other_flags = '0, psw, pe = '0;
    logic [31:0] rd;
    int fails = 0, checked = 0, cycles = 0;
    logic [31:0] sa [9] = '{32'h4040_0000, 32'h4040_0000, 32'h3F80_0000, 32'h4040_0000, 32'h4040_0000,
        32'h7F80_0000, 32'h3F80_0000, 32'h7F80_0000, 32'h8000_0000};
    logic [31:0] sb [9] = '{32'h0, 32'h4040_0000, 32'h4040_0000, 32'h3F80_0000, 32'hFFFF_FFFF,
        32'hFF80_0000, 32'h0040_0000, 32'h7F80_0000, 32'h0};
    logic [6:0] tf [9] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h10, 7'h00, 7'h20, 7'h00, 7'h00};
    logic [8:0] ge = 9'h1EB, gt = 9'h069;
    always #50 clk = ~clk;
    float_compare_ge_gt_unit i_float_compare_ge_gt_unit(.clk(clk), .sys_rst(sys_rst), .issue(issue),
        .other_flags(other_flags), .result(result), .program_status_word(psw), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .irq(irq));
    dest_regfile i_dest_regfile(.clk(clk), .result(result));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(negedge clk);
    endtask
    task automatic op(input logic [7:0] c, input logic [2:0] s, input logic g, input logic [31:0] a, b,
        input logic [6:0] d, input logic [6:0] f);
        @(posedge clk);
        issue <= '{1'b1, s, c, {31'h0, g}, a, b, d};
        other_flags <= f;
        @(posedge clk);
        issue.valid <= 1'b0;
        other_flags <= '0;
        @(negedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK("psw reset", 7'h00, psw)
        for (int i = 0; i < 9; i++) begin
            op(OP_GEQ, 3'h3, 1'b1, sa[i], sb[i], 7'h10, 7'h00);
            pe |= tf[i];
            `CHK("geq", {31'h0, ge[i]}, result.data)
            `CHK("psw", pe, psw)
            op(OP_GTR, 3'h3, 1'b1, sa[i], sb[i], 7'h11, 7'h00);
            `CHK("gtr", {31'h0, gt[i]}, result.data)
            op(OP_GEQ_FLAGS, 3'h3, 1'b1, sa[i], sb[i], 7'h12, 7'h00);
            `CHK("vector", {25'h0, tf[i]}, result.data)
            `CHK("write", 1'b1, result.write)
        end
        $display("compare table done");
        wb(1'b1, ADR_PSW, 32'h0);
        wb(1'b0, ADR_PSW, 32'h0);
        `CHK("psw clear", 32'h0, rd)
        op(OP_GEQ, 3'h3, 1'b0, sa[4], sb[4], 7'h10, 7'h00);
        `CHK("guard write", 1'b0, result.write)
        op(OP_GEQ_FLAGS, 3'h3, 1'b0, sa[4], sb[4], 7'h12, 7'h00);
        @(negedge clk);
        `CHK("guard dest", 32'h1, i_dest_regfile.regs_q[16])
        `CHK("guard vector", 32'h0, i_dest_regfile.regs_q[18])
        `CHK("guard psw", 7'h00, psw)
        op(OP_GTR, 3'h3, 1'b1, sa[4], sb[4], 7'h11, 7'h41);
        `CHK("or merge", 7'h51, psw)
        wb(1'b0, ADR_UNIT_STATUS, 32'h0);
        `CHK("last vector", 32'h10, rd)
        $display("guard and merge done");
        `CHK("irq masked", 1'b0, irq)
        wb(1'b1, ADR_IRQ_STATUS, 32'h7);
        wb(1'b1, ADR_IRQ_MASK, 32'h4);
        op(OP_GEQ, 3'h2, 1'b1, sa[0], sb[0], 7'h13, 7'h00);
        `CHK("slot write", 1'b0, result.write)
        wb(1'b0, ADR_IRQ_STATUS, 32'h0);
        `CHK("events", 32'h4, rd)
        `CHK("irq on", 1'b1, irq)
        wb(1'b1, ADR_IRQ_STATUS, 32'h4);
        `CHK("irq off", 1'b0, irq)
        wb(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        $display("events done");
        summarize();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end
endmodule
